// ### verilog/ffd_pkg.sv
// Package for the four-format instruction decoder: opcodes, field positions, decoded types.
`default_nettype none
package ffd_pkg;
    localparam int BYTE_W  = 8;
    localparam int REG_W   = 4;
    localparam int DISP_W  = 12;
    localparam int LEN_W   = 9;
    localparam int DLEN_W  = 5;
    localparam int INSN_W  = 48;
    localparam int CNT_W   = 3;

    // Field positions as MSB indices into the left-justified instruction image (bit 47 = MSB)
    localparam int FLD_OP_MSB     = 47;
    localparam int FLD_REG1_MSB   = 39;
    localparam int FLD_REG2_MSB   = 35;
    localparam int FLD_IMM_MSB    = 39;
    localparam int FLD_LEN_MSB    = 39;
    localparam int FLD_LEN1_MSB   = 39;
    localparam int FLD_LEN2_MSB   = 35;
    localparam int FLD_BASE1_MSB  = 31;
    localparam int FLD_DISP1_MSB  = 27;
    localparam int FLD_BASE2_MSB  = 15;
    localparam int FLD_DISP2_MSB  = 11;
    localparam int BASE_IDX_BIT   = 3;

    localparam logic [REG_W-1:0]  RX_PAD_VALUE = 4'h0;
    localparam logic [CNT_W-1:0]  LEN_REG = 3'h2;
    localparam logic [CNT_W-1:0]  LEN_RX  = 3'h4;
    localparam logic [CNT_W-1:0]  LEN_SI  = 3'h4;
    localparam logic [CNT_W-1:0]  LEN_SS  = 3'h6;
    localparam logic [CNT_W-1:0]  LEN_BAD = 3'h1;

    // Recognised codes in the order of ffd_op_e, grouped by layout
    localparam int NUM_OPS = 37;
    localparam logic [7:0] OPC_TABLE [NUM_OPS] = '{
        8'h07, 8'h0d, 8'h1a, 8'h1b,
        8'h40, 8'h47, 8'h48, 8'h49, 8'h4a, 8'h4b, 8'h4d,
        8'h81, 8'h83, 8'h91, 8'h92, 8'h94, 8'h95, 8'h96, 8'h99, 8'h9a, 8'h9b,
        8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd5, 8'hdc, 8'hde,
        8'hf1, 8'hf2, 8'hf3, 8'hf8, 8'hf9, 8'hfa, 8'hfb, 8'hfc, 8'hfd};
    localparam int FIRST_RX = 4, FIRST_SI = 11, FIRST_SSL = 21, FIRST_SSD = 28;
    localparam logic [NUM_OPS-1:0] FIXED_MASK = 37'h3dc;

    typedef enum logic [2:0] {
        reg_reg_layout = 3'h0, reg_storage_layout = 3'h1, storage_imm_layout = 3'h2,
        ss_logical_layout = 3'h3, ss_decimal_layout = 3'h4, no_layout = 3'h7
    } ffd_layout_e;

    typedef enum logic [5:0] {
        branch_cond_reg_op, branch_link_reg_op, add_reg_op, sub_reg_op,
        store_half_op, branch_cond_storage_op, load_half_op, compare_half_op,
        add_half_op, sub_half_op, branch_link_storage_op,
        set_status_word_op, diagnostic_op, test_mask_op, move_immediate_op, and_immediate_op,
        compare_immediate_op, or_immediate_op, halt_proceed_op, test_io_branch_op, control_io_op,
        transfer_io_op, move_numeric_op, move_chars_op, move_zone_op, compare_chars_op,
        translate_op, edit_op,
        move_offset_op, pack_decimal_op, unpack_decimal_op, zero_add_decimal_op,
        compare_decimal_op, add_decimal_op, sub_decimal_op, mul_decimal_op, div_decimal_op,
        invalid_op
    } ffd_op_e;

    typedef enum logic [1:0] {
        dest_first_reg = 2'h0, dest_second_storage = 2'h1, dest_first_storage = 2'h2,
        dest_none = 2'h3
    } ffd_dest_e;

    typedef enum logic [1:0] {
        ST_OPCODE = 2'b00, ST_FETCH = 2'b01, ST_HOLD = 2'b11
    } ffd_state_e;

    typedef struct packed {
        ffd_op_e     op;
        ffd_layout_e layout;
        logic        fixed_point;
        logic        valid;
    } ffd_class_s;

    typedef struct packed {
        logic [BYTE_W-1:0] opcode;
        ffd_op_e           op;
        ffd_layout_e       layout;
        logic              invalid;
        logic              fixed_point;
        logic              pad_error;
        ffd_dest_e         dest;
        logic              gr_preserved;
        logic              second_in_storage;
        logic [REG_W-1:0]  first_reg_designator;
        logic [REG_W-1:0]  second_reg_designator;
        logic [REG_W-1:0]  first_base_field;
        logic [DISP_W-1:0] first_displacement_field;
        logic              first_indexed;
        logic [REG_W-1:0]  second_base_field;
        logic [DISP_W-1:0] second_displacement_field;
        logic              second_indexed;
        logic [BYTE_W-1:0] immediate_byte_field;
        logic [BYTE_W-1:0] length_field;
        logic [LEN_W-1:0]  operand_bytes;
        logic [REG_W-1:0]  first_length_code;
        logic [REG_W-1:0]  second_length_code;
        logic [DLEN_W-1:0] first_operand_bytes;
        logic [DLEN_W-1:0] second_operand_bytes;
    } ffd_decode_s;
endpackage
`default_nettype wire

// ### verilog/ffd_decoder.sv
// Four-format instruction decoder: assembles instruction bytes and decodes fields and class.
// Operation
// - Five layouts covering thirty-seven operations.
// - First byte selects operation and layout.
// - Logical storage-storage length from second byte.
// - Fixed-point only in register layouts.
// - Register-register designators in bits 8-15.
// - Fixed-point register result to first register.
// - Recognise four register-register codes.
// - Register-storage fields: register, zero pad, base, displacement.
// - Storage address from base and displacement.
// - Register result, except store halfword to storage.
// - Recognise seven register-storage codes.
// - Immediate first operand one storage byte.
// - Immediate second operand is instruction byte.
// - Immediate result overwrites first storage byte.
// - Recognise ten storage-immediate codes.
// - Logical shared length, up to 256 bytes.
// - Operand length equals field plus one.
// - Logical writes first field, registers untouched.
// - Recognise seven logical storage-storage codes.
// - Decimal two length codes, 1 to 16 bytes.
// - Decimal replaces first field; overlap allowed.
// - Recognise nine decimal codes.
// - Base high bit selects indexing.
`default_nettype none
module ffd_decoder (
    input  wire logic                  sys_clk,
    input  wire logic                  resetn,
    input  wire logic                  fetch_valid,
    input  wire logic [ffd_pkg::BYTE_W-1:0] fetch_byte,
    output logic                       fetch_ready,
    output logic                       dec_valid,
    input  wire logic                  exec_ready,
    output ffd_pkg::ffd_decode_s       dec,
    output logic [ffd_pkg::CNT_W-1:0]  insn_bytes
);
    import ffd_pkg::*;

    typedef struct packed {
        ffd_state_e        state;
        logic [INSN_W-1:0] image;
        logic [CNT_W-1:0]  count;
        logic [CNT_W-1:0]  need;
        ffd_decode_s       out;
    } ffd_regs_s;

    ffd_regs_s r;
    ffd_regs_s next_r;

    // Table lookup: the layout follows from the group a code sits in
    function automatic ffd_class_s classify(input logic [BYTE_W-1:0] opc);
        ffd_class_s c;
        c = '{op: invalid_op, layout: no_layout, fixed_point: 1'b0, valid: 1'b0};
        for (int k = 0; k < NUM_OPS; k++) begin
            if (opc == OPC_TABLE[k]) begin
                c.op          = ffd_op_e'(k);
                c.valid       = 1'b1;
                c.fixed_point = FIXED_MASK[k];
                c.layout      = (k < FIRST_RX)  ? reg_reg_layout :
                                (k < FIRST_SI)  ? reg_storage_layout :
                                (k < FIRST_SSL) ? storage_imm_layout :
                                (k < FIRST_SSD) ? ss_logical_layout : ss_decimal_layout;
            end
        end
        // Fixed-point can only come out of the register layouts
        if (c.layout != reg_reg_layout && c.layout != reg_storage_layout) begin
            c.fixed_point = 1'b0;
        end
        return c;
    endfunction

    function automatic logic [CNT_W-1:0] length_of(input ffd_layout_e lay);
        logic [CNT_W-1:0] n;
        n = LEN_BAD;
        unique case (lay)
            reg_reg_layout:     n = LEN_REG;
            reg_storage_layout: n = LEN_RX;
            storage_imm_layout: n = LEN_SI;
            ss_logical_layout,
            ss_decimal_layout:  n = LEN_SS;
            default:            n = LEN_BAD;
        endcase
        return n;
    endfunction

    // Used for both base fields
    function automatic logic is_indexed(input logic [REG_W-1:0] base);
        return base[BASE_IDX_BIT];
    endfunction

    // Pure field decode of a complete, left-justified instruction image
    function automatic ffd_decode_s decode(input logic [INSN_W-1:0] img);
        ffd_decode_s d;
        ffd_class_s  c;
        d = '0;
        d.opcode = img[FLD_OP_MSB -: BYTE_W];
        c = classify(d.opcode);
        d.op          = c.op;
        d.layout      = c.layout;
        d.invalid     = !c.valid;
        d.fixed_point = c.fixed_point;
        d.dest        = dest_none;
        unique case (c.layout)
            reg_reg_layout: begin
                d.first_reg_designator  = img[FLD_REG1_MSB -: REG_W];
                d.second_reg_designator = img[FLD_REG2_MSB -: REG_W];
                // Branches on this layout write nothing back to a register operand
                d.dest = c.fixed_point ? dest_first_reg : dest_none;
            end
            reg_storage_layout: begin
                d.first_reg_designator     = img[FLD_REG1_MSB -: REG_W];
                d.pad_error                = img[FLD_REG2_MSB -: REG_W] != RX_PAD_VALUE;
                d.second_base_field        = img[FLD_BASE1_MSB -: REG_W];
                d.second_displacement_field = img[FLD_DISP1_MSB -: DISP_W];
                d.second_indexed           = is_indexed(img[FLD_BASE1_MSB -: REG_W]);
                d.second_in_storage        = 1'b1;
                d.dest = (c.op == store_half_op) ? dest_second_storage : dest_first_reg;
            end
            storage_imm_layout: begin
                d.immediate_byte_field     = img[FLD_IMM_MSB -: BYTE_W];
                d.first_base_field         = img[FLD_BASE1_MSB -: REG_W];
                d.first_displacement_field = img[FLD_DISP1_MSB -: DISP_W];
                d.first_indexed            = is_indexed(img[FLD_BASE1_MSB -: REG_W]);
                d.operand_bytes            = LEN_W'(1);
                d.dest                     = dest_first_storage;
            end
            ss_logical_layout, ss_decimal_layout: begin
                d.length_field              = img[FLD_LEN_MSB -: BYTE_W];
                d.first_base_field          = img[FLD_BASE1_MSB -: REG_W];
                d.first_displacement_field  = img[FLD_DISP1_MSB -: DISP_W];
                d.first_indexed             = is_indexed(img[FLD_BASE1_MSB -: REG_W]);
                d.second_base_field         = img[FLD_BASE2_MSB -: REG_W];
                d.second_displacement_field = img[FLD_DISP2_MSB -: DISP_W];
                d.second_indexed            = is_indexed(img[FLD_BASE2_MSB -: REG_W]);
                d.second_in_storage         = 1'b1;
                d.gr_preserved              = 1'b1;
                d.dest                      = dest_first_storage;
                if (c.layout == ss_logical_layout) begin
                    // One length serves both operands, counted beyond the leftmost byte
                    d.operand_bytes = {1'b0, img[FLD_LEN_MSB -: BYTE_W]} + LEN_W'(1);
                end else begin
                    d.first_length_code    = img[FLD_LEN1_MSB -: REG_W];
                    d.second_length_code   = img[FLD_LEN2_MSB -: REG_W];
                    d.first_operand_bytes  = {1'b0, img[FLD_LEN1_MSB -: REG_W]} + DLEN_W'(1);
                    d.second_operand_bytes = {1'b0, img[FLD_LEN2_MSB -: REG_W]} + DLEN_W'(1);
                end
            end
            default: begin
                d.dest = dest_none;
            end
        endcase
        return d;
    endfunction

    ffd_class_s  head_class;
    logic        take_byte;
    logic [CNT_W-1:0] head_need;
    logic [INSN_W-1:0] merged;

    always_comb begin
        head_class = classify(fetch_byte);
        head_need  = length_of(head_class.layout);
        take_byte  = fetch_valid && fetch_ready;
        merged     = r.image;
        // Byte k of the instruction lands at image bits [47-8k -: 8]
        merged[INSN_W-1 - BYTE_W*int'(r.count) -: BYTE_W] = fetch_byte;
    end

    always_comb begin
        next_r = r;
        unique case (r.state)
            ST_OPCODE: begin
                if (take_byte) begin
                    next_r.image = '0;
                    next_r.image[FLD_OP_MSB -: BYTE_W] = fetch_byte;
                    next_r.count = CNT_W'(1);
                    next_r.need  = head_need;
                    // An unknown code is answered at once; no operand bytes are taken for it
                    if (!head_class.valid) begin
                        next_r.out   = decode({fetch_byte, (INSN_W-BYTE_W)'(0)});
                        next_r.state = ST_HOLD;
                    end else begin
                        next_r.state = ST_FETCH;
                    end
                end
            end
            ST_FETCH: begin
                if (take_byte) begin
                    next_r.image = merged;
                    next_r.count = r.count + CNT_W'(1);
                    if (r.count + CNT_W'(1) == r.need) begin
                        next_r.out   = decode(merged);
                        next_r.state = ST_HOLD;
                    end
                end
            end
            ST_HOLD: begin
                if (exec_ready) begin
                    next_r.state = ST_OPCODE;
                    next_r.count = '0;
                end
            end
            default: begin
                next_r.state = ST_OPCODE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // Fetch stalls while a decoded instruction waits for execution control
    assign fetch_ready = (r.state != ST_HOLD);
    assign dec_valid   = (r.state == ST_HOLD);
    assign dec         = r.out;
    assign insn_bytes  = r.need;

endmodule // ffd_decoder
`default_nettype wire

// ### testbench/ffd_decoder_sva.sv
// Checker for the four-format decoder ports, bound to the decoder.
`default_nettype none
module ffd_decoder_chk (
    input wire logic                       sys_clk,
    input wire logic                       resetn,
    input wire logic                       fetch_valid,
    input wire logic [ffd_pkg::BYTE_W-1:0] fetch_byte,
    input wire logic                       fetch_ready,
    input wire logic                       dec_valid,
    input wire logic                       exec_ready,
    input wire ffd_pkg::ffd_decode_s       dec,
    input wire logic [ffd_pkg::CNT_W-1:0]  insn_bytes
);
    import ffd_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    property p_hold; dec_valid && !exec_ready |=> dec_valid && $stable(dec); endproperty
    a_hold: assert property (p_hold) else $error("decode changed while held");
    property p_rise; $rose(dec_valid) |-> $past(fetch_valid) && $past(fetch_ready); endproperty
    a_rise: assert property (p_rise) else $error("decode without byte");
    property p_free; dec_valid && exec_ready |=> !dec_valid && fetch_ready; endproperty
    a_free: assert property (p_free) else $error("decode not released");
    property p_fix;
        dec_valid && dec.fixed_point |-> dec.layout inside {reg_reg_layout, reg_storage_layout};
    endproperty
    a_fix: assert property (p_fix) else $error("fixed point outside register layouts");
    property p_ssl;
        dec_valid && dec.layout == ss_logical_layout |->
            dec.operand_bytes == 9'(dec.length_field) + 9'h1 && dec.gr_preserved;
    endproperty
    a_ssl: assert property (p_ssl) else $error("logical length wrong");
    property p_ssd;
        dec_valid && dec.layout == ss_decimal_layout |->
            dec.first_operand_bytes == 5'(dec.first_length_code) + 5'h1 &&
            dec.second_operand_bytes == 5'(dec.second_length_code) + 5'h1;
    endproperty
    a_ssd: assert property (p_ssd) else $error("decimal lengths wrong");
    property p_idx;
        dec_valid |-> dec.first_indexed == dec.first_base_field[3] &&
            dec.second_indexed == dec.second_base_field[3];
    endproperty
    a_idx: assert property (p_idx) else $error("indexing flag wrong");
    property p_sth; dec_valid && dec.op == store_half_op |-> dec.dest == dest_second_storage;
    endproperty
    a_sth: assert property (p_sth) else $error("store destination wrong");
    property p_si;
        dec_valid && dec.layout == storage_imm_layout |->
            dec.dest == dest_first_storage && dec.operand_bytes == 9'h1;
    endproperty
    a_si: assert property (p_si) else $error("immediate operand wrong");
    property p_bad; dec_valid && dec.invalid |-> dec.op == invalid_op && insn_bytes == LEN_BAD;
    endproperty
    a_bad: assert property (p_bad) else $error("invalid opcode not flagged");
endmodule // ffd_decoder_chk
bind ffd_decoder ffd_decoder_chk u_chk (.sys_clk(sys_clk), .resetn(resetn),
    .fetch_valid(fetch_valid), .fetch_byte(fetch_byte), .fetch_ready(fetch_ready),
    .dec_valid(dec_valid), .exec_ready(exec_ready), .dec(dec), .insn_bytes(insn_bytes));
`default_nettype wire

// ### testbench/ffd_fetch_model.sv
// Instruction fetch model: streams instruction bytes, opcode first, optionally with gaps.
`default_nettype none
module ffd_fetch_model (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        go,
    input  wire logic [47:0] insn,
    input  wire logic [2:0]  nbytes,
    input  wire logic        slow,
    input  wire logic        fetch_ready,
    output logic             fetch_valid,
    output logic [7:0]       fetch_byte
);
    logic [47:0] sh;
    logic [2:0]  left;
    logic        gap;
    // Idle byte lane shows the inverse of the last byte so nothing stale looks valid
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            fetch_valid <= 1'b0;
            fetch_byte  <= 8'h00;
            sh          <= '0;
            left        <= '0;
            gap         <= 1'b0;
        end else if (go) begin
            sh          <= insn;
            left        <= nbytes;
            fetch_valid <= 1'b1;
            fetch_byte  <= insn[47:40];
        end else if (fetch_valid && fetch_ready) begin
            sh   <= sh << 8;
            left <= left - 3'h1;
            if (left == 3'h1 || slow) begin
                fetch_valid <= 1'b0;
                fetch_byte  <= ~fetch_byte;
                gap         <= (left != 3'h1);
            end else begin
                fetch_byte <= sh[39:32];
            end
        end else if (gap) begin
            gap         <= 1'b0;
            fetch_valid <= 1'b1;
            fetch_byte  <= sh[47:40];
        end
    end
endmodule // ffd_fetch_model
`default_nettype wire

// ### testbench/tb_ffd_decoder.sv
// Self-checking bench for the four-format instruction decoder.
`default_nettype none
module tb_ffd_decoder;
    timeunit 1ns;
    timeprecision 1ps;
    import ffd_pkg::*;
    logic        sys_clk = 1'b0, resetn = 1'b0, go = 1'b0, slow = 1'b0, exec_ready = 1'b0;
    logic [47:0] insn = '0;
    logic [2:0]  nbytes = '0;
    logic        fetch_valid, fetch_ready, dec_valid;
    logic [7:0]  fetch_byte;
    logic [2:0]  insn_bytes;
    ffd_decode_s dec;
    int          err_total = 0, checked = 0, cycles = 0;
    always #2 sys_clk = ~sys_clk;
    ffd_fetch_model u_src (.sys_clk(sys_clk), .resetn(resetn), .go(go), .insn(insn),
        .nbytes(nbytes), .slow(slow), .fetch_ready(fetch_ready), .fetch_valid(fetch_valid),
        .fetch_byte(fetch_byte));
    ffd_decoder DUT (.sys_clk(sys_clk), .resetn(resetn), .fetch_valid(fetch_valid),
        .fetch_byte(fetch_byte), .fetch_ready(fetch_ready), .dec_valid(dec_valid),
        .exec_ready(exec_ready), .dec(dec), .insn_bytes(insn_bytes));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic wait_dec;
        int i;
        i = 0;
        while (dec_valid !== 1'b1 && i < 40) begin
            @(posedge sys_clk);
            #1;
            i++;
        end
        chk(16'(i < 40), 16'h1, "decode wait");
    endtask
    task automatic put(input logic [47:0] w, input logic [2:0] n, input logic s);
        @(posedge sys_clk);
        insn <= w;
        nbytes <= n;
        slow <= s;
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        wait_dec;
    endtask
    task automatic take;
        @(posedge sys_clk);
        exec_ready <= 1'b1;
        @(posedge sys_clk);
        exec_ready <= 1'b0;
        #1;
        chk(16'(dec_valid), 16'h0, "release");
    endtask
    task automatic t_r2r;
        for (int i = 0; i < 4; i++) begin
            put({OPC_TABLE[i], 4'(i + 3), 4'hc, 32'h0}, 3'h2, i[0]);
            chk(16'(dec.op), 16'(i), "r2r op");
            chk(16'(dec.layout), 16'(reg_reg_layout), "r2r layout");
            chk({dec.first_reg_designator, dec.second_reg_designator}, {4'(i + 3), 4'hc},
                "r2r regs");
            chk(16'(dec.dest), 16'((i > 1) ? dest_first_reg : dest_none), "r2r dest");
            chk(16'(insn_bytes), 16'(LEN_REG), "r2r len");
            take;
        end
        $display("test r2r done");
    endtask
    task automatic t_rx;
        logic [6:0] fp;
        fp = 7'b0111101;
        for (int i = 0; i < 7; i++) begin
            put({OPC_TABLE[FIRST_RX + i], 4'h5, 4'(i == 6), i[0] ? 4'h9 : 4'h2, 12'habc, 16'h0},
                3'h4, 1'b0);
            chk(16'(dec.op), 16'(FIRST_RX + i), "rx op");
            chk({dec.first_reg_designator, dec.second_base_field, 8'(dec.second_indexed)},
                {4'h5, i[0] ? 4'h9 : 4'h2, 8'(i[0])}, "rx fields");
            chk(16'(dec.second_displacement_field), 16'habc, "rx disp");
            chk(16'(dec.dest), 16'((i == 0) ? dest_second_storage : dest_first_reg), "rx dest");
            chk({dec.fixed_point, dec.pad_error, 11'h0, insn_bytes}, {fp[i], i == 6, 11'h0, LEN_RX},
                "rx flags");
            take;
        end
        $display("test rx done");
    endtask
    task automatic t_si;
        for (int i = 0; i < 10; i++) begin
            put({OPC_TABLE[FIRST_SI + i], 8'(8'h5a + i), 4'ha, 12'h123, 16'h0}, 3'h4, i[0]);
            chk(16'(dec.op), 16'(FIRST_SI + i), "si op");
            chk({dec.immediate_byte_field, 8'(dec.second_in_storage)}, {8'(8'h5a + i), 8'h0},
                "si imm");
            chk({dec.first_base_field, dec.first_displacement_field}, 16'ha123, "si addr");
            chk(16'(dec.dest), 16'(dest_first_storage), "si dest");
            chk({dec.fixed_point, 12'h0, insn_bytes}, {1'b0, 12'h0, LEN_SI}, "si len");
            take;
        end
        $display("test si done");
    endtask
    task automatic t_ssl;
        logic [7:0] n;
        for (int i = 0; i < 7; i++) begin
            n = (i == 0) ? 8'hff : 8'(i * 37 - 37);
            put({OPC_TABLE[FIRST_SSL + i], n, 4'h3, 12'h456, 4'hb, 12'h789}, 3'h6, i[0]);
            chk(16'(dec.op), 16'(FIRST_SSL + i), "ssl op");
            chk({dec.length_field, 8'(insn_bytes)}, {n, 8'(LEN_SS)}, "ssl len");
            chk(16'(dec.operand_bytes), 16'(n) + 16'h1, "ssl bytes");
            chk({dec.first_base_field, dec.first_displacement_field}, 16'h3456, "ssl op1");
            chk({dec.second_base_field, dec.second_displacement_field}, 16'hb789, "ssl op2");
            chk({dec.gr_preserved, 13'h0, dec.dest}, {1'b1, 13'h0, dest_first_storage}, "ssl dest");
            take;
        end
        $display("test ssl done");
    endtask
    task automatic t_ssd;
        logic [3:0] a;
        for (int i = 0; i < 9; i++) begin
            a = 4'(i * 15 / 8);
            put({OPC_TABLE[FIRST_SSD + i], a, 4'hf - a, 4'h1, 12'h0ff, 4'hc, 12'h001}, 3'h6, 1'b0);
            chk(16'(dec.op), 16'(FIRST_SSD + i), "ssd op");
            chk({3'h0, dec.first_operand_bytes, 3'h0, dec.second_operand_bytes},
                {3'h0, 5'(a) + 5'h1, 3'h0, 5'h10 - 5'(a)}, "ssd lens");
            chk({dec.dest, dec.fixed_point, 10'h0, insn_bytes}, {dest_first_storage, 11'h0, LEN_SS},
                "ssd dest");
            take;
        end
        $display("test ssd done");
    endtask
    task automatic t_bad;
        put({8'h00, OPC_TABLE[2], 8'h12, 24'h0}, 3'h3, 1'b0);
        chk({dec.invalid, 7'h0, 8'(insn_bytes)}, {1'b1, 7'h0, 8'(LEN_BAD)}, "bad flag");
        chk(16'(dec.op), 16'(invalid_op), "bad op");
        chk(16'(fetch_ready), 16'h0, "refused");
        take;
        wait_dec;
        chk({8'(dec.op), dec.first_reg_designator, dec.second_reg_designator},
            {8'(add_reg_op), 8'h12}, "after bad");
        take;
        $display("test bad done");
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            $display("CHECK FAILED at %0t: run too long", $time);
            conclude;
        end
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        #1;
        chk({fetch_ready, dec_valid, insn_bytes}, 16'h10, "reset");
        t_r2r;
        t_rx;
        t_si;
        t_ssl;
        t_ssd;
        t_bad;
        conclude;
    end
endmodule // tb_ffd_decoder
`default_nettype wire
